// [input_cond_map.vh]
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - per-group filter: 0 or 3..15 ms
// - every group defaults to 3 ms
// - higher inputs use fixed 3 ms filter
// - pulses shorter than value minus 2ms rejected
// - pulses at least filter value always pass
// - input registers at scan end after filtering
// - special-function inputs bypass the noise filter
// - analog channels give 0..1000 read-only values
// - 0..10 V always; current only with option
// - non-analog terminal acts as discrete input
// - analog values and status refresh every scan
// - overflow bit above 11 V or 21 mA
// - status 0 normal, 2 initializing value 0
// - status 1 during first conversion only
// - parameter error: status 3, hold value
// - over range: status 5, value maximum
// - below 2 mA: status 6, value minimum
// - filter count 0 off, else average n
// - one sample per scan, sum divided by samples held (up to n)
// - per-channel filter count and signal type
`ifndef INPUT_COND_MAP_VH
`define INPUT_COND_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CH0_VALUE     8'h00
`define OFS_CH1_VALUE     8'h04
`define OFS_CH0_STATUS    8'h08
`define OFS_CH1_STATUS    8'h0C
`define OFS_OVERFLOW      8'h10
`define OFS_DFILT_CFG     8'h14
`define OFS_BYPASS_MASK   8'h18
`define OFS_ACH0_CFG      8'h1C
`define OFS_ACH1_CFG      8'h20
`define OFS_DIN_STATE     8'h24

// ****************************************************************
// reset values and fields
// ****************************************************************
`define DFILT_RESET       16'h3333
`define DFILT_DEFAULT     4'h3
`define FIXED_FILT_MS     4'h3
`define ACFG_EN_BIT       0
`define ACFG_CUR_BIT      1
`define ACFG_CNT_LSB      8

// ****************************************************************
// analog codes and thresholds (raw: 1000 = 10 V or 20 mA)
// ****************************************************************
`define ST_NORMAL         16'h0000
`define ST_CONVERT        16'h0001
`define ST_INIT           16'h0002
`define ST_PARAM_ERR      16'h0003
`define ST_OVER           16'h0005
`define ST_OPEN           16'h0006
`define VAL_MAX           11'h3E8
`define VAL_FULL          10'h3E8
`define RAW_V_OVER        11'h44C
`define RAW_I_OVER        11'h41A
`define RAW_I_ZERO        11'h0C8
`define RAW_I_OPEN        11'h064

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS     100
`define TICK_PERIOD_NS    1000000
`define TICK_CYCLES       (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [input_cond.v]
`include "input_cond_map.vh"

module input_cond #(
  parameter        TICK_CYCLES = `TICK_CYCLES,  // pclk cycles per 1 ms tick
  parameter        CURRENT_OPT = 1,             // 1: current range fitted
  parameter        NUM_DIN     = 16             // discrete inputs, 8 grouped
) (
  input  wire               pclk,
  input  wire               presetn,
  input  wire [7:0]         paddr,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  input  wire               scan_end,
  input  wire [NUM_DIN-1:0] din_pin,
  output reg  [NUM_DIN-1:0] din_scan_q,
  input  wire [10:0]        adc_raw_0,
  input  wire [10:0]        adc_raw_1,
  input  wire               adc_ready_0,
  input  wire               adc_ready_1
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  reg  [15:0]        dfilt_q;      // four 4-bit group filter values
  reg  [NUM_DIN-1:0] bypass_q;     // input used by counter/irq/freq
  reg  [15:0]        acfg_q [0:1]; // analog enable, type, count
  reg  [1:0]         acfg_wr_q;    // pulse: analog config rewritten
  reg  [1:0]         ovf_q;        // overflow word bits
  reg  [15:0]        tick_cnt_q;   // ms tick prescaler
  reg                tick_q;       // one-cycle 1 ms tick

  wire       wr_acc = psel & penable & pwrite;
  wire       rd_set = psel & ~penable;
  wire [10:0] raw   [0:1];
  wire [1:0]  rdy;

  assign raw[0] = adc_raw_0;
  assign raw[1] = adc_raw_1;
  assign rdy    = {adc_ready_1, adc_ready_0};

  // group filter value for an input; higher inputs are fixed
  function [3:0] filt_val;
    input [15:0] cfg;
    input integer idx;
    begin
      if (idx < 8) begin
        filt_val = cfg[(idx/2)*4 +: 4];
      end else begin
        filt_val = `FIXED_FILT_MS;
      end
    end
  endfunction

  // illegal 1 or 2 ms are raised to the smallest legal value
  function [3:0] legal_filt;
    input [3:0] v;
    begin
      if (v == 4'h1 || v == 4'h2) begin
        legal_filt = `DFILT_DEFAULT;
      end else begin
        legal_filt = v;
      end
    end
  endfunction

  // clamp a scaled code to full scale; over-range has its own status
  function [9:0] clamp_full;
    input [12:0] v;
    begin
      if (v > {2'b00, `VAL_MAX}) begin
        clamp_full = `VAL_FULL;
      end else begin
        clamp_full = v[9:0];
      end
    end
  endfunction

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  // free-running prescaler; all pulse widths are counted in ticks
  // the prescaler length is one 1 ms tick and sets every discrete input filter's grain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES[15:0] - 16'h0001) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // writes land in the access phase; config change restarts averaging
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dfilt_q   <= `DFILT_RESET;
      bypass_q  <= {NUM_DIN{1'b0}};
      acfg_q[0] <= 16'h0000;
      acfg_q[1] <= 16'h0000;
      acfg_wr_q <= 2'b00;
    end else begin
      acfg_wr_q <= 2'b00;
      if (wr_acc) begin
        case (paddr)
          `OFS_DFILT_CFG: begin
            dfilt_q <= {legal_filt(pwdata[15:12]), legal_filt(pwdata[11:8]),
                        legal_filt(pwdata[7:4]), legal_filt(pwdata[3:0])};
          end
          `OFS_BYPASS_MASK: begin
            bypass_q <= pwdata[NUM_DIN-1:0];
          end
          `OFS_ACH0_CFG: begin
            acfg_q[0] <= pwdata[15:0];
            acfg_wr_q <= 2'b01;
          end
          `OFS_ACH1_CFG: begin
            acfg_q[1] <= pwdata[15:0];
            acfg_wr_q <= 2'b10;
          end
          default: begin
            acfg_wr_q <= 2'b00;          // read-only and unmapped: dropped
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // discrete input filters
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIN; gi = gi + 1) begin : din_f
      reg        s1_q;   // first stage, read only by s2_q
      reg        s2_q;
      reg        s3_q;
      reg        lvl_q;  // level once s2 and s3 agree
      reg        flt_q;  // filtered level
      reg  [3:0] cnt_q;  // ticks spent at the opposite level
      wire [3:0] fv  = filt_val(dfilt_q, gi);
      // analog terminals 6 and 7 skip filtering when analog is on
      wire       byp = bypass_q[gi] |
                       ((gi == 6) ? acfg_q[0][`ACFG_EN_BIT] : 1'b0) |
                       ((gi == 7) ? acfg_q[1][`ACFG_EN_BIT] : 1'b0);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
          flt_q <= 1'b0;
          cnt_q <= 4'h0;
        end else begin
          s1_q <= din_pin[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
          if (byp || fv == 4'h0) begin
            flt_q <= lvl_q;
            cnt_q <= 4'h0;
          end else if (lvl_q == flt_q) begin
            // restarting here keeps a burst of short glitches from
            // adding up to one long pulse
            cnt_q <= 4'h0;               // glitch ended: start over
          end else if (tick_q) begin
            // fv-1 ticks: a pulse of fv ms always sees them, one
            // under fv-2 ms never does; tick phase sets the band
            if (cnt_q + 4'h1 >= fv - 4'h1) begin
              flt_q <= lvl_q;
              cnt_q <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // scan-end capture of discrete inputs
  // ****************************************************************
  // one scan after the filter passes, the program sees the level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_scan_q <= {NUM_DIN{1'b0}};
    end else if (scan_end) begin : cap
      integer k;
      for (k = 0; k < NUM_DIN; k = k + 1) begin
        din_scan_q[k] <= din_f_lvl(k);
      end
    end
  end

  wire [NUM_DIN-1:0] flt_all;
  generate
    for (gi = 0; gi < NUM_DIN; gi = gi + 1) begin : flt_pack
      assign flt_all[gi] = din_f[gi].flt_q;
    end
  endgenerate

  function din_f_lvl;
    input integer k;
    begin
      din_f_lvl = flt_all[k];
    end
  endfunction

  // ****************************************************************
  // analog channels
  // ****************************************************************
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : ach
      reg  [9:0]  hist [0:255]; // past scan samples for averaging
      reg  [7:0]  ptr_q;        // next history slot
      reg  [8:0]  fill_q;       // samples gathered so far
      reg  [17:0] sum_q;        // running sum of the window
      reg         seen_q;       // first conversion finished
      reg  [15:0] val_q;
      reg  [15:0] stat_q;
      wire        en   = acfg_q[gc][`ACFG_EN_BIT];
      wire        cur  = acfg_q[gc][`ACFG_CUR_BIT];
      wire [7:0]  n    = acfg_q[gc][`ACFG_CNT_LSB +: 8];
      wire [10:0] r    = raw[gc];
      // current option absent: asking for current is a setting error
      wire        perr = cur && (CURRENT_OPT == 0);
      wire        over = cur ? (r > `RAW_I_OVER) : (r > `RAW_V_OVER);
      wire        open = cur && (r < `RAW_I_OPEN);
      // 4..20 mA span stretched by 5/4: (r - 200) + (r - 200) / 4
      wire [12:0] isc  = {2'b00, r - `RAW_I_ZERO} +
                         {4'b0000, r[10:2]} - {2'b00, `RAW_I_ZERO >> 2};
      reg  [9:0]  samp;   // scaled instantaneous sample
      reg  [17:0] sum_n;
      reg  [8:0]  fill_n;
      reg  [17:0] avg;

      // scale to 0..1000: volts direct, 4..20 mA by 5/4 above 4 mA
      always @* begin
        samp = 10'h000;
        if (!cur) begin
          samp = clamp_full({2'b00, r});
        end else if (r > `RAW_I_ZERO) begin
          samp = clamp_full(isc);
        end
      end

      // running window sum; short history divides by what it has
      always @* begin
        sum_n  = sum_q + {8'h00, samp};
        fill_n = fill_q;
        if (fill_q < {1'b0, n}) begin
          fill_n = fill_q + 9'h001;
        end else begin
          sum_n = sum_q + {8'h00, samp} - {8'h00, hist[ptr_q - n]};
        end
        if (n == 8'h00) begin
          avg = {8'h00, samp};
        end else begin
          avg = sum_n / {9'h000, fill_n};
        end
      end

      always @(posedge pclk) begin
        // written only on scans that also advance the window; a config
        // write in the same cycle wins, and that sample is dropped
        if (scan_end && en && !perr && seen_q && !over && !open &&
            n != 8'h00 && !acfg_wr_q[gc]) begin
          hist[ptr_q] <= samp;
        end
      end

      // refresh value and status once per scan, in priority order
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ptr_q  <= 8'h00;
          fill_q <= 9'h000;
          sum_q  <= 18'h0_0000;
          seen_q <= 1'b0;
          val_q  <= 16'h0000;
          stat_q <= `ST_INIT;
        end else if (acfg_wr_q[gc]) begin
          ptr_q  <= 8'h00;               // new count: restart window
          fill_q <= 9'h000;
          sum_q  <= 18'h0_0000;
        end else if (scan_end) begin
          if (rdy[gc]) begin
            seen_q <= 1'b1;
          end
          if (!en) begin
            stat_q <= `ST_INIT;
            val_q  <= 16'h0000;
          end else if (perr) begin
            stat_q <= `ST_PARAM_ERR;
          end else if (!seen_q) begin
            stat_q <= `ST_CONVERT;
          end else if (over) begin
            stat_q <= `ST_OVER;
            val_q  <= {6'h00, `VAL_FULL};
          end else if (open) begin
            stat_q <= `ST_OPEN;
            val_q  <= 16'h0000;
          end else begin
            stat_q <= `ST_NORMAL;
            val_q  <= {6'h00, avg[9:0]};
            if (n != 8'h00) begin
              ptr_q  <= ptr_q + 8'h01;
              fill_q <= fill_n;
              sum_q  <= sum_n;
            end
          end
        end
      end
    end
  endgenerate

  // overflow word follows the live signal each scan
  // a disabled channel never raises its bit, whatever its pin shows
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 2'b00;
    end else if (scan_end) begin
      ovf_q <= {ach[1].en & ach[1].over,
                ach[0].en & ach[0].over};
    end
  end

  // ****************************************************************
  // APB read path
  // ****************************************************************
  // data is latched in the setup cycle so pready can stay high:
  // every transfer ends after exactly one access cycle
  // pslverr only counts with pready; it stands until the next setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_set) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
        case (paddr)
          `OFS_CH0_VALUE:   prdata[15:0] <= ach[0].val_q;
          `OFS_CH1_VALUE:   prdata[15:0] <= ach[1].val_q;
          `OFS_CH0_STATUS:  prdata[15:0] <= ach[0].stat_q;
          `OFS_CH1_STATUS:  prdata[15:0] <= ach[1].stat_q;
          `OFS_OVERFLOW:    prdata[1:0]  <= ovf_q;
          `OFS_DFILT_CFG:   prdata[15:0] <= dfilt_q;
          `OFS_BYPASS_MASK: prdata[NUM_DIN-1:0] <= bypass_q;
          `OFS_ACH0_CFG:    prdata[15:0] <= acfg_q[0];
          `OFS_ACH1_CFG:    prdata[15:0] <= acfg_q[1];
          `OFS_DIN_STATE:   prdata[NUM_DIN-1:0] <= din_scan_q;
          default: begin
            pslverr <= 1'b1;             // unmapped: error, data zero
          end
        endcase
      end
    end
  end

endmodule

// [input_cond_properties.sv]
// ********************************************************************
// bus and scan checks seen from the block's ports
// ********************************************************************
module input_cond_properties #(
  parameter NUM_DIN = 16  // width of the captured input word
) (
  input logic               pclk,
  input logic               presetn,
  input logic [7:0]         paddr,
  input logic               psel,
  input logic               penable,
  input logic               pwrite,
  input logic [31:0]        prdata,
  input logic               pready,
  input logic               pslverr,
  input logic               scan_end,
  input logic [NUM_DIN-1:0] din_scan_q
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // setup cycle of a read; its data is loaded one edge later
  logic rd_setup;
  assign rd_setup = psel && !penable && !pwrite;

  property p_ready; presetn |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low after reset");

  property p_val_range; rd_setup && paddr[7:3] == 5'h00 |=> prdata <= 32'h0000_03e8; endproperty
  a_val_range: assert property (p_val_range) else $error("value above full scale");

  property p_stat_code;
    rd_setup && (paddr == 8'h08 || paddr == 8'h0c)
      |=> prdata[31:3] == 29'h0 && prdata[2:0] != 3'h4 && prdata[2:0] != 3'h7;
  endproperty
  a_stat_code: assert property (p_stat_code) else $error("reserved status code");

  property p_ovf_bits; rd_setup && paddr == 8'h10 |=> prdata[31:2] == 30'h0; endproperty
  a_ovf_bits: assert property (p_ovf_bits) else $error("extra overflow bits");

  // unmapped places answer with an error and no data
  property p_unmapped; psel && !penable && paddr > 8'h24 |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_mapped; psel && !penable && paddr <= 8'h24 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");

  // read data must not move under the master after the access phase
  property p_rd_stable; psel && penable |=> $stable(prdata); endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");

  // inputs are only captured at end of scan
  property p_scan_hold; !scan_end |=> $stable(din_scan_q); endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("inputs moved mid-scan");
endmodule

bind input_cond input_cond_properties #(.NUM_DIN(NUM_DIN)) u_input_cond_properties (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scan_end(scan_end), .din_scan_q(din_scan_q));

// [field_model.sv]
// ********************************************************************
// field side: switches on discrete pins and two analog converters
// ********************************************************************
module field_model (
  input  logic        pclk,
  output logic [15:0] din_pin,
  output logic [10:0] adc_raw_0,
  output logic [10:0] adc_raw_1,
  output logic        adc_ready_0,
  output logic        adc_ready_1
);
  timeunit 1ns;
  timeprecision 1ps;

  // converters need a while after power-up before a first result
  initial begin
    din_pin = 16'h0000;
    adc_raw_0 = 11'h000;
    adc_raw_1 = 11'h000;
    adc_ready_0 = 1'b0;
    adc_ready_1 = 1'b0;
    repeat (30) @(posedge pclk);
    adc_ready_0 <= 1'b1;
    adc_ready_1 <= 1'b1;
  end

  // one high pulse of len clocks, called just after a rising edge
  task automatic pulse(input int idx, input int len);
    din_pin[idx] <= 1'b1;
    repeat (len) @(posedge pclk);
    din_pin[idx] <= 1'b0;
  endtask

  // new converter codes for both channels
  task automatic set_raw(input logic [10:0] v0, input logic [10:0] v1);
    adc_raw_0 <= v0;
    adc_raw_1 <= v1;
  endtask
endmodule

// [tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scan_end;
  logic [15:0] din_pin;
  logic [15:0] din_scan_q;
  logic [10:0] adc_raw_0;
  logic [10:0] adc_raw_1;
  logic        adc_ready_0;
  logic        adc_ready_1;
  int          n_fail;
  int          num_checks;

  // short tick keeps the millisecond filters to a few clocks
  input_cond #(.TICK_CYCLES(10), .CURRENT_OPT(1), .NUM_DIN(16)) u_input_cond (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scan_end(scan_end), .din_pin(din_pin), .din_scan_q(din_scan_q),
    .adc_raw_0(adc_raw_0), .adc_raw_1(adc_raw_1), .adc_ready_0(adc_ready_0),
    .adc_ready_1(adc_ready_1));

  field_model u_field_model (
    .pclk(pclk), .din_pin(din_pin), .adc_raw_0(adc_raw_0), .adc_raw_1(adc_raw_1),
    .adc_ready_0(adc_ready_0), .adc_ready_1(adc_ready_1));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; a free idle cycle after it avoids double drives
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("reg_%h", a), r, exp);
  endtask

  task automatic scan();
    scan_end <= 1'b1;
    @(posedge pclk);
    scan_end <= 1'b0;
    @(posedge pclk);
  endtask

  // pulse a pin, end the scan at clock 'at', then let the filter settle
  task automatic dpulse(input int idx, input int len, input int at, input logic exp);
    fork
      u_field_model.pulse(idx, len);
    join_none
    repeat (at) @(posedge pclk);
    scan();
    chk("din_scan_q", 32'(din_scan_q[idx]), 32'(exp));
    repeat (200) @(posedge pclk);
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd(8'h14, 32'h0000_3333);
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0002);
    rd(8'h10, 32'h0000_0000);
    apb(1'b0, 8'h28, 32'h0, r, e);
    chk("pslverr", 32'(e), 32'h0000_0001);
    $display("t_reset done");
  endtask

  // the first scan that sees the converter ready still reports status 1
  task automatic t_analog();
    u_field_model.set_raw(11'h1f4, 11'h063);
    wr(8'h1c, 32'h0000_0001);
    wr(8'h20, 32'h0000_0003);
    scan();
    rd(8'h08, 32'h0000_0001);
    rd(8'h0c, 32'h0000_0001);
    scan();
    rd(8'h08, 32'h0000_0001);
    scan();
    rd(8'h00, 32'h0000_01f4);
    rd(8'h08, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h0c, 32'h0000_0006);
    u_field_model.set_raw(11'h44d, 11'h41b);
    scan();
    rd(8'h00, 32'h0000_03e8);
    rd(8'h08, 32'h0000_0005);
    rd(8'h0c, 32'h0000_0005);
    rd(8'h10, 32'h0000_0003);
    u_field_model.set_raw(11'h44c, 11'h258);
    scan();
    rd(8'h10, 32'h0000_0000);
    rd(8'h00, 32'h0000_03e8);
    rd(8'h04, 32'h0000_01f4);
    wr(8'h04, 32'h0000_1234);
    rd(8'h04, 32'h0000_01f4);
    $display("t_analog done");
  endtask

  task automatic t_avg();
    logic [31:0] avg [5];
    avg = '{32'h0000_0064, 32'h0000_0096, 32'h0000_00c8, 32'h0000_00fa, 32'h0000_015e};
    wr(8'h1c, 32'h0000_0401);
    for (int i = 0; i < 5; i++) begin
      u_field_model.set_raw(11'(i + 1) * 11'h064, 11'h258);
      scan();
      rd(8'h00, avg[i]);
    end
    wr(8'h1c, 32'h0000_0000);
    wr(8'h20, 32'h0000_0000);
    scan();
    rd(8'h08, 32'h0000_0002);
    rd(8'h00, 32'h0000_0000);
    $display("t_avg done");
  endtask

  task automatic t_filter();
    wr(8'h14, 32'h0000_f012);
    rd(8'h14, 32'h0000_f033);
    wr(8'h18, 32'h0000_0004);
    dpulse(0, 9, 17, 1'b0);
    dpulse(0, 30, 38, 1'b1);
    dpulse(4, 20, 10, 1'b1);
    dpulse(2, 20, 10, 1'b1);
    dpulse(3, 20, 10, 1'b0);
    dpulse(6, 120, 128, 1'b0);
    dpulse(6, 150, 158, 1'b1);
    dpulse(8, 9, 17, 1'b0);
    dpulse(8, 30, 38, 1'b1);
    // terminal 7 as analog input skips its 15 ms group filter
    wr(8'h20, 32'h0000_0001);
    dpulse(7, 20, 10, 1'b1);
    wr(8'h20, 32'h0000_0000);
    $display("t_filter done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    scan_end = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_analog();
    t_avg();
    t_filter();
    test_done();
  end
endmodule
